// *** core/alm_regs.vh ***
// Function
// - Unmasked set flag plus enable pulls alert low
// - Mask one blocks, zero passes; not read-cleared
// - Status mask gates status flags 0,3-6 bit for bit; flags 1,2 never alert
// - Status mask bits 0,3-6, reset 0x79
// - Unmasked result update with enable alerts
// - Volt/temp mask gates six flags, reset 0x3F
// - Current/power mask gates four flags, reset 0xF
// - Charge mask gates four flags, reset 0x3F
// - Energy mask gates energy flags, reset 0x3F
// - Energy bits 0-2: energy1 high, low; energy2 high
// - Conditions reported only after 200ms persistence
`ifndef ALM_REGS_VH
`define ALM_REGS_VH

// Register offsets on the internal register port
`define ALM_STATUS_ADDR 8'h80
`define ALM_VT_FLAG_ADDR 8'h81
`define ALM_IP_FLAG_ADDR 8'h82
`define ALM_CHG_FLAG_ADDR 8'h83
`define ALM_NRG_FLAG_ADDR 8'h84
`define ALM_STATUS_MASK_ADDR 8'h88
`define ALM_VT_MASK_ADDR 8'h89
`define ALM_IP_MASK_ADDR 8'h8a
`define ALM_CHG_MASK_ADDR 8'h8b
`define ALM_NRG_MASK_ADDR 8'h8c

// Reset values of the mask registers
`define ALM_STATUS_MASK_RST 8'h79
`define ALM_VT_MASK_RST 8'h3f
`define ALM_IP_MASK_RST 8'h0f
`define ALM_CHG_MASK_RST 8'h3f
`define ALM_NRG_MASK_RST 8'h3f

// Bits held by each mask register; the rest read zero
`define ALM_STATUS_MASK_IMPL 8'h79
`define ALM_VT_MASK_IMPL 8'h3f
`define ALM_IP_MASK_IMPL 8'h0f
`define ALM_CHG_MASK_IMPL 8'h3f
`define ALM_NRG_MASK_IMPL 8'h3f

// Status mask field positions
`define ALM_ANALOG_UV_BIT 0
`define ALM_DIGITAL_UV_BIT 3
`define ALM_REFRESH_BIT 4
`define ALM_CONV_FAULT_BIT 5
`define ALM_TIMEBASE_FAULT_BIT 6

// Flag group widths
`define ALM_VT_W 6
`define ALM_IP_W 4
`define ALM_CHG_W 4
`define ALM_NRG_W 4

// Persistence time before a condition is reported
`define ALM_PERSIST_MS 200
`define ALM_CLK_KHZ 250000
`define ALM_PERSIST_CYC (`ALM_PERSIST_MS * `ALM_CLK_KHZ)
`define ALM_PERSIST_CW 26

`endif

// *** core/alm_persist.v ***
`timescale 1ns/1ps
// Per-bit persistence qualifier: a condition is passed on only
// once it has stood without a break for CYC clock cycles.
module alm_persist #(
  parameter N = 18,
  parameter CW = 26,
  parameter CYC = 50000000
) (
  input wire mclk,
  input wire rstn,
  input wire [N-1:0] cond_raw,
  output wire [N-1:0] cond_qual
);

  // Saturation point of each counter, cut to the counter width
  localparam integer LIM_FULL = CYC - 1;
  localparam [CW-1:0] LIM = LIM_FULL[CW-1:0];

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_bit
      reg [CW-1:0] cnt_reg; // Cycles the condition has stood
      reg qual_reg; // Qualified condition

      // Any drop restarts the count, so glitches never report
      always @(posedge mclk) begin
        if (!rstn) begin
          cnt_reg <= {CW{1'b0}};
          qual_reg <= 1'b0;
        end else if (!cond_raw[i]) begin
          cnt_reg <= {CW{1'b0}};
          qual_reg <= 1'b0;
        end else begin
          if (cnt_reg != LIM) begin
            cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
          end
          qual_reg <= (cnt_reg == LIM);
        end
      end
      assign cond_qual[i] = qual_reg;
    end
  endgenerate

endmodule // alm_persist

// *** core/alm_mask_reg.v ***
`timescale 1ns/1ps
// One read/write alert mask register on the internal port
module alm_mask_reg #(
  parameter [7:0] ADDR = 8'h88,
  parameter [7:0] RST = 8'hff,
  parameter [7:0] IMPL = 8'hff
) (
  input wire mclk,
  input wire rstn,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  output wire [7:0] mask_q
);

  reg [7:0] mask_reg; // Stored mask, only held bits are kept

  // Plain storage; reading has no side effect on it
  always @(posedge mclk) begin
    if (!rstn) begin
      mask_reg <= RST & IMPL;
    end else if (wr_en && (wr_addr == ADDR)) begin
      mask_reg <= wr_data & IMPL;
    end
  end

  assign mask_q = mask_reg;

endmodule // alm_mask_reg

// *** core/alm_top.v ***
`timescale 1ns/1ps
`include "alm_regs.vh"
// Alert masking: qualifies threshold conditions, keeps the
// alert flag and mask registers, and drives the open-drain
// alert pin toward the host.
module alm_top #(
  parameter PERSIST_CYC = `ALM_PERSIST_CYC,
  parameter CNT_W = `ALM_PERSIST_CW
) (
  input wire mclk,
  input wire rstn,
  // Internal register port, one byte per access
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Status flags, already held by the status logic
  input wire [6:0] status_flags,
  // Raw threshold conditions from the comparators
  input wire [`ALM_VT_W-1:0] volt_temp_cond,
  input wire [`ALM_IP_W-1:0] current_power_cond,
  input wire [`ALM_CHG_W-1:0] charge_cond,
  input wire [`ALM_NRG_W-1:0] energy_cond,
  // Master enable of the alert pin
  input wire pin_master_enable,
  // Open-drain alert pin, low when driven
  output wire alert_out,
  output wire alert_oe
);

  // Total width of the qualified flag groups
  // Widths come from the header, so one edit resizes every slice
  localparam FW = `ALM_VT_W + `ALM_IP_W + `ALM_CHG_W + `ALM_NRG_W;
  // Start of each group inside the flag vector
  localparam IP_LO = `ALM_VT_W;
  localparam CHG_LO = IP_LO + `ALM_IP_W;
  localparam NRG_LO = CHG_LO + `ALM_CHG_W;

  wire [FW-1:0] cond_raw; // All raw conditions
  wire [FW-1:0] cond_qual; // Conditions after persistence
  reg [FW-1:0] flag_reg; // Sticky alert flags
  reg [FW-1:0] flag_next; // Next value of the flags
  reg [FW-1:0] flag_clr; // Flags cleared by this read

  wire [7:0] status_mask; // Status event mask
  wire [7:0] vt_mask; // Volt/temp alarm mask
  wire [7:0] ip_mask; // Current/power alarm mask
  wire [7:0] chg_mask; // Charge alarm mask
  wire [7:0] nrg_mask; // Energy alarm mask

  // Individual status mask fields, for readability
  wire analog_undervolt_mask;
  wire digital_undervolt_mask;
  wire result_refresh_mask;
  wire conversion_fault_mask;
  wire timebase_fault_mask;

  wire [7:0] status_vec; // Status flags widened to a byte
  wire status_hit; // Some status flag passes its mask
  wire vt_hit; // Some volt/temp flag passes
  wire ip_hit; // Some current/power flag passes
  wire chg_hit; // Some charge flag passes
  wire nrg_hit; // Some energy flag passes
  wire any_hit; // Any unmasked flag is set
  reg alert_oe_reg; // Registered pin drive enable
  reg [7:0] rdata_next; // Read data before the output flop

  // Gather the raw conditions in register order
  // Bit order matches the flag bytes, so group slices line up
  assign cond_raw = {energy_cond, charge_cond,
                     current_power_cond, volt_temp_cond};

  // Persistence filter for every threshold condition
  alm_persist #(
    .N(FW),
    .CW(CNT_W),
    .CYC(PERSIST_CYC)
  ) u_persist (
    .mclk(mclk),
    .rstn(rstn),
    .cond_raw(cond_raw),
    .cond_qual(cond_qual)
  );

  // Read of a flag register clears that whole group
  // A read of the status byte or of a mask clears nothing, so
  // the host may poll those without losing an alert
  always @* begin
    flag_clr = {FW{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `ALM_VT_FLAG_ADDR: begin
          flag_clr[IP_LO-1:0] = {`ALM_VT_W{1'b1}};
        end
        `ALM_IP_FLAG_ADDR: begin
          flag_clr[CHG_LO-1:IP_LO] = {`ALM_IP_W{1'b1}};
        end
        `ALM_CHG_FLAG_ADDR: begin
          flag_clr[NRG_LO-1:CHG_LO] = {`ALM_CHG_W{1'b1}};
        end
        `ALM_NRG_FLAG_ADDR: begin
          flag_clr[FW-1:NRG_LO] = {`ALM_NRG_W{1'b1}};
        end
        default: begin
          flag_clr = {FW{1'b0}};
        end
      endcase
    end
  end

  // A qualified condition in the clearing cycle still sets,
  // so an event that lands on the read is never lost
  always @* begin
    flag_next = (flag_reg & ~flag_clr) | cond_qual;
  end

  // Sticky flag storage
  // Reset empties every flag, as the counters restart as well
  always @(posedge mclk) begin
    if (!rstn) begin
      flag_reg <= {FW{1'b0}};
    end else begin
      flag_reg <= flag_next;
    end
  end

  // The five masks share the write port and differ only in
  // offset, reset value and held bits
  // Status event mask
  alm_mask_reg #(
    .ADDR(`ALM_STATUS_MASK_ADDR),
    .RST(`ALM_STATUS_MASK_RST),
    .IMPL(`ALM_STATUS_MASK_IMPL)
  ) u_status_mask (
    .mclk(mclk),
    .rstn(rstn),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .mask_q(status_mask)
  );

  // Volt/temp alarm mask
  alm_mask_reg #(
    .ADDR(`ALM_VT_MASK_ADDR),
    .RST(`ALM_VT_MASK_RST),
    .IMPL(`ALM_VT_MASK_IMPL)
  ) u_vt_mask (
    .mclk(mclk),
    .rstn(rstn),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .mask_q(vt_mask)
  );

  // Current/power alarm mask
  alm_mask_reg #(
    .ADDR(`ALM_IP_MASK_ADDR),
    .RST(`ALM_IP_MASK_RST),
    .IMPL(`ALM_IP_MASK_IMPL)
  ) u_ip_mask (
    .mclk(mclk),
    .rstn(rstn),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .mask_q(ip_mask)
  );

  // Charge alarm mask
  alm_mask_reg #(
    .ADDR(`ALM_CHG_MASK_ADDR),
    .RST(`ALM_CHG_MASK_RST),
    .IMPL(`ALM_CHG_MASK_IMPL)
  ) u_chg_mask (
    .mclk(mclk),
    .rstn(rstn),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .mask_q(chg_mask)
  );

  // Energy alarm mask
  alm_mask_reg #(
    .ADDR(`ALM_NRG_MASK_ADDR),
    .RST(`ALM_NRG_MASK_RST),
    .IMPL(`ALM_NRG_MASK_IMPL)
  ) u_nrg_mask (
    .mclk(mclk),
    .rstn(rstn),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .mask_q(nrg_mask)
  );

  // Named status mask fields
  // Bits 1 and 2 of the mask are not held and read back zero
  assign analog_undervolt_mask = status_mask[`ALM_ANALOG_UV_BIT];
  assign digital_undervolt_mask = status_mask[`ALM_DIGITAL_UV_BIT];
  assign result_refresh_mask = status_mask[`ALM_REFRESH_BIT];
  assign conversion_fault_mask = status_mask[`ALM_CONV_FAULT_BIT];
  assign timebase_fault_mask = status_mask[`ALM_TIMEBASE_FAULT_BIT];

  // Bit 7 of the status byte has no source and reads zero
  assign status_vec = {1'b0, status_flags};

  // Status flags pass where their mask bit is zero; bits 1
  // and 2 have no mask and never raise the pin
  assign status_hit =
    (status_vec[`ALM_ANALOG_UV_BIT] & ~analog_undervolt_mask) |
    (status_vec[`ALM_DIGITAL_UV_BIT] & ~digital_undervolt_mask) |
    (status_vec[`ALM_REFRESH_BIT] & ~result_refresh_mask) |
    (status_vec[`ALM_CONV_FAULT_BIT] & ~conversion_fault_mask) |
    (status_vec[`ALM_TIMEBASE_FAULT_BIT] & ~timebase_fault_mask);

  // Threshold groups, masked bit for bit
  assign vt_hit = |(flag_reg[IP_LO-1:0] &
                    ~vt_mask[`ALM_VT_W-1:0]);
  assign ip_hit = |(flag_reg[CHG_LO-1:IP_LO] &
                    ~ip_mask[`ALM_IP_W-1:0]);
  assign chg_hit = |(flag_reg[NRG_LO-1:CHG_LO] &
                     ~chg_mask[`ALM_CHG_W-1:0]);
  // Energy bits: energy1 high, energy1 low, energy2 high, then
  // energy2 low, which the held mask bit 3 gates as well
  assign nrg_hit = |(flag_reg[FW-1:NRG_LO] &
                     ~nrg_mask[`ALM_NRG_W-1:0]);

  // One unmasked flag in any group is enough to want the pin
  assign any_hit = status_hit | vt_hit | ip_hit | chg_hit | nrg_hit;

  // Limitation: the pin follows flags and masks one clock late
  // after the cause, and a flag cleared by a read frees it then
  // Pin drive: registered so the pin cannot glitch on
  // combinational hazards between the flag and mask paths
  always @(posedge mclk) begin
    if (!rstn) begin
      alert_oe_reg <= 1'b0;
    end else begin
      alert_oe_reg <= pin_master_enable & any_hit;
    end
  end

  // Open drain: only ever pulls low, released otherwise
  // The value is fixed low; only the enable ever moves
  assign alert_out = 1'b0;
  assign alert_oe = alert_oe_reg;

  // Read mux; unmapped offsets answer zero
  // Flag bytes carry their group in the low bits, the rest zero
  always @* begin
    case (reg_addr)
      `ALM_STATUS_ADDR: begin
        rdata_next = status_vec;
      end
      `ALM_VT_FLAG_ADDR: begin
        rdata_next = {{(8-`ALM_VT_W){1'b0}}, flag_reg[IP_LO-1:0]};
      end
      `ALM_IP_FLAG_ADDR: begin
        rdata_next = {{(8-`ALM_IP_W){1'b0}}, flag_reg[CHG_LO-1:IP_LO]};
      end
      `ALM_CHG_FLAG_ADDR: begin
        rdata_next = {{(8-`ALM_CHG_W){1'b0}},
                      flag_reg[NRG_LO-1:CHG_LO]};
      end
      `ALM_NRG_FLAG_ADDR: begin
        rdata_next = {{(8-`ALM_NRG_W){1'b0}}, flag_reg[FW-1:NRG_LO]};
      end
      `ALM_STATUS_MASK_ADDR: begin
        rdata_next = status_mask;
      end
      `ALM_VT_MASK_ADDR: begin
        rdata_next = vt_mask;
      end
      `ALM_IP_MASK_ADDR: begin
        rdata_next = ip_mask;
      end
      `ALM_CHG_MASK_ADDR: begin
        rdata_next = chg_mask;
      end
      `ALM_NRG_MASK_ADDR: begin
        rdata_next = nrg_mask;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Read data is captured on the strobe and then held, so the
  // serial front end may shift it out at its own pace; a burst
  // over 0x80..0x84 captures each byte in its own read cycle
  always @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

endmodule // alm_top

// *** tb/alm_checker.sv ***
`timescale 1ns/1ps
// Port-level watch on the alert mask block
module alm_checker #(
  parameter PERSIST_CYC = 8
) (
  input wire mclk,
  input wire rstn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [6:0] status_flags,
  input wire pin_master_enable,
  input wire alert_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Pin and read data leave reset idle
  property p_rst_idle;
    $rose(rstn) |-> !alert_oe && reg_rdata == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs not idle after reset");
  // No pull-down without the master enable
  property p_gate_off;
    !pin_master_enable |=> !alert_oe;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("alert driven while disabled");
  // Status byte is a read-through of the flags
  property p_stat_rd;
    reg_rd && reg_addr == 8'h80 |=> reg_rdata == {1'b0, $past(status_flags)};
  endproperty
  a_stat_rd: assert property (p_stat_rd)
    else $error("status read mismatch");
  // Read data only moves on a read
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  // Mask write then read returns held bits only
  property p_smask;
    reg_wr && reg_addr == 8'h88 ##1 reg_rd && reg_addr == 8'h88
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h79);
  endproperty
  a_smask: assert property (p_smask)
    else $error("status mask read-back");
  property p_ipmask;
    reg_wr && reg_addr == 8'h8a ##1 reg_rd && reg_addr == 8'h8a
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0f);
  endproperty
  a_ipmask: assert property (p_ipmask)
    else $error("current/power mask read-back");
  property p_nrgmask;
    reg_wr && reg_addr == 8'h8c ##1 reg_rd && reg_addr == 8'h8c
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f);
  endproperty
  a_nrgmask: assert property (p_nrgmask)
    else $error("energy mask read-back");
  // Volt/temp flag byte has six bits
  property p_vt_w;
    reg_rd && reg_addr == 8'h81 |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_vt_w: assert property (p_vt_w)
    else $error("volt/temp flag upper bits set");
endmodule // alm_checker

bind alm_top alm_checker #(.PERSIST_CYC(PERSIST_CYC)) chk_u (
  .mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .status_flags(status_flags), .pin_master_enable(pin_master_enable),
  .alert_oe(alert_oe));

// *** tb/alm_host_model.sv ***
`timescale 1ns/1ps
// Host side of the open-drain alert wire
module alm_host_model (
  input wire alert_out,
  input wire alert_oe,
  output wire alert_n
);
  // Pull-up holds the line high whenever nobody pulls it down
  assign alert_n = alert_oe ? alert_out : 1'b1;
endmodule // alm_host_model

// *** tb/test_alert_mask_logic.sv ***
`timescale 1ns/1ps
module test_alert_mask_logic;
  localparam PC = 8; // Short persistence keeps the run brief
  logic mclk, rstn, reg_wr, reg_rd, pme;
  logic [7:0] reg_addr, reg_wdata;
  logic [6:0] sflags;
  logic [17:0] cvec; // Raw conditions, groups packed low to high
  wire [7:0] reg_rdata;
  wire alert_out, alert_oe, alert_n;
  int fail_count, checks, cyc, g, b, a;
  logic [7:0] madr [5] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c};
  logic [7:0] mimp [5] = '{8'h79, 8'h3f, 8'h0f, 8'h3f, 8'h3f};
  int gw [4] = '{6, 4, 4, 4};
  int go [4] = '{0, 6, 10, 14};
  alm_top #(.PERSIST_CYC(PC)) dut_u (.mclk(mclk), .rstn(rstn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .status_flags(sflags),
    .volt_temp_cond(cvec[5:0]), .current_power_cond(cvec[9:6]),
    .charge_cond(cvec[13:10]), .energy_cond(cvec[17:14]),
    .pin_master_enable(pme), .alert_out(alert_out), .alert_oe(alert_oe));
  alm_host_model host_u (.alert_out(alert_out), .alert_oe(alert_oe),
    .alert_n(alert_n));
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  // Hang guard, far above the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Strobes stay up so that accesses can run back to back
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    reg_rd = 0; reg_wr = 1; reg_addr = ad; reg_wdata = d;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    reg_wr = 0; reg_rd = 1; reg_addr = ad;
    @(negedge mclk);
    chk(reg_rdata, e);
  endtask
  task automatic idle(input int n);
    reg_wr = 0; reg_rd = 0;
    repeat (n) @(negedge mclk);
  endtask
  task automatic pin(input logic e);
    chk({7'h00, alert_n}, {7'h00, e});
  endtask
  task results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    rstn = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    sflags = 0; cvec = 0; pme = 0;
    // Count rising edges, so the clock's first step at time zero
    // cannot shorten the reset to one edge
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rstn = 1;
    // Reset values, read-back, and a nonzero value read twice so
    // that a clear on read would show
    for (g = 0; g < 5; g++) begin
      rd(madr[g], mimp[g]);
      wr(madr[g], 8'h00);
      rd(madr[g], 8'h00);
      wr(madr[g], 8'hff);
      rd(madr[g], mimp[g]);
      rd(madr[g], mimp[g]);
    end
    idle(2); pin(1'b1);
    $display("mask register test done");
    // Status bits 1 and 2 have no mask and never alert
    pme = 1; sflags = 7'h06; wr(8'h88, 8'h00);
    idle(3); pin(1'b1);
    for (b = 0; b < 7; b++) if (mimp[0][b]) begin
      wr(8'h88, mimp[0] & ~(8'h01 << b));
      sflags = ~(7'h01 << b);
      idle(3); pin(1'b1);
      sflags = 7'h7f;
      idle(2); pin(1'b0);
      pme = 0;
      idle(2); pin(1'b1);
      pme = 1; wr(8'h88, mimp[0]);
      idle(2); pin(1'b1);
    end
    sflags = 0;
    $display("status mask test done");
    // Every threshold flag: short pulse, then a held condition
    for (g = 0; g < 4; g++) for (b = 0; b < gw[g]; b++) begin
      // One edge short of qualifying must leave no flag behind
      cvec = 18'h1 << (go[g] + b); idle(PC - 1);
      cvec = 0; idle(4);
      rd(8'h81 + g[7:0], 8'h00);
      cvec = 18'h1 << (go[g] + b); idle(PC + 3);
      wr(8'h89 + g[7:0], mimp[g + 1] & ~(8'h01 << b));
      idle(2); pin(1'b0);
      cvec = 0; idle(3);
      for (a = 0; a < 5; a++)
        rd(8'h80 + a[7:0], (a == g + 1) ? 8'h01 << b : 8'h00);
      rd(8'h81 + g[7:0], 8'h00);
      idle(2); pin(1'b1);
      wr(8'h89 + g[7:0], mimp[g + 1]);
    end
    idle(1);
    $display("threshold mask test done");
    // A reset in mid-run must bring written masks back to their
    // reset values and leave the pin released
    for (g = 0; g < 5; g++) wr(madr[g], 8'h00);
    rstn = 0; idle(2);
    rstn = 1;
    for (g = 0; g < 5; g++)
      rd(madr[g], mimp[g]);
    idle(2); pin(1'b1);
    $display("mid-run reset test done");
    results;
  end
endmodule // test_alert_mask_logic
